/* design/smnco_pkg.sv */
// Summary of operation
// - mode 00 rms/ms magnitude, 01 peak, 10 and 11 threshold crossing
// - channel a 20-bit result in three read-only bytes, lsb lowest address
// - channel b 20-bit result in three bytes, bits 19:16 low nibble
// - 32-bit tuning word from four bytes in ascending address order
// - sync gate and master sync set: sync pulse reloads phase offset
package smnco_pkg;
  localparam logic [9:0] smnco_monitor_control = 10'h112;
  localparam logic [9:0] smnco_period_low = 10'h113;
  localparam logic [9:0] smnco_period_mid = 10'h114;
  localparam logic [9:0] smnco_period_high = 10'h115;
  localparam logic [9:0] smnco_result_a_low = 10'h116;
  localparam logic [9:0] smnco_result_a_mid = 10'h117;
  localparam logic [9:0] smnco_result_a_high = 10'h118;
  localparam logic [9:0] smnco_result_b_low = 10'h119;
  localparam logic [9:0] smnco_result_b_mid = 10'h11a;
  localparam logic [9:0] smnco_result_b_high = 10'h11b;
  localparam logic [9:0] smnco_oscillator_control = 10'h11d;
  localparam logic [9:0] smnco_tuning_byte0 = 10'h11e;
  localparam logic [9:0] smnco_tuning_byte1 = 10'h11f;
  localparam logic [9:0] smnco_tuning_byte2 = 10'h120;
  localparam logic [9:0] smnco_tuning_byte3 = 10'h121;
  localparam logic [9:0] smnco_phase_byte0 = 10'h122;
  localparam logic [9:0] smnco_phase_byte1 = 10'h123;
  localparam logic [23:0] smnco_period_reset = 24'h000080;
  // monitor_control fields
  localparam int smnco_ctl_enable = 0;
  localparam int smnco_ctl_mode_lo = 1;
  localparam int smnco_ctl_ms_sel = 3;
  localparam int smnco_ctl_complex = 7;
  // oscillator_control fields
  localparam int smnco_osc_enable = 0;
  localparam int smnco_osc_amp_dither = 1;
  localparam int smnco_osc_phase_dither = 2;
  localparam logic [1:0] smnco_mode_rms = 2'h0;
  localparam logic [1:0] smnco_mode_peak = 2'h1;
endpackage

/* design/smnco_chan.sv */
`timescale 1ns/1ps
module smnco_chan
  import smnco_pkg::*;
#(
  parameter int sample_w = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [sample_w-1:0] sample,
  input wire logic [1:0] mode,
  input wire logic ms_sel,
  input wire logic [sample_w-1:0] threshold,
  input wire logic start,
  input wire logic done,
  output logic [19:0] result
);
  typedef struct packed {
    logic [39:0] acc;
    logic [19:0] result;
  } smnco_chan_state_t;
  smnco_chan_state_t state, next_state;
  logic [27:0] sq;
  logic [39:0] acc_in;
  logic [19:0] rms;

  // integer square root of the 40-bit sum, 20-bit answer
  function automatic logic [19:0] smnco_isqrt(input logic [39:0] v);
    logic [19:0] r;
    r = 20'h00000;
    for (int i = 19; i >= 0; i--) begin
      if ({20'h00000, r | (20'h00001 << i)} * {20'h00000, r | (20'h00001 << i)} <= {24'h000000, v})
        r = r | (20'h00001 << i);
    end
    return r;
  endfunction

  always_comb begin
    next_state = state;
    sq = 28'(sample) * 28'(sample);
    acc_in = start ? 40'h0 : state.acc;
    case (mode)
      smnco_mode_rms: next_state.acc = acc_in + 40'(sq);
      smnco_mode_peak: next_state.acc = (40'(sample) > acc_in) ? 40'(sample) : acc_in;
      default: next_state.acc = acc_in + ((sample > threshold) ? 40'h1 : 40'h0);
    endcase
    // rms or mean-square report
    // the closing sample is folded in, so a window spans exactly period cycles
    rms = smnco_isqrt(next_state.acc);
    if (done) begin
      if (mode == smnco_mode_rms)
        next_state.result = ms_sel ? next_state.acc[39:20] : rms;
      else
        next_state.result = next_state.acc[19:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end
  assign result = state.result;
endmodule

/* design/smnco_regs.sv */
`timescale 1ns/1ps
module smnco_regs
  import smnco_pkg::*;
#(
  parameter int sample_w = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [sample_w-1:0] sample_a,
  input wire logic [sample_w-1:0] sample_b,
  input wire logic [sample_w-1:0] threshold,
  input wire logic sync_pulse,
  input wire logic master_sync_enable,
  input wire logic oscillator_sync_gate,
  output logic monitor_enable,
  output logic complex_power_mode,
  output logic [31:0] tuning_oscillator_phase,
  output logic oscillator_enable,
  output logic amplitude_dither,
  output logic phase_dither
);
  typedef struct packed {
    logic [7:0] monitor_control;
    logic [23:0] period;
    logic [7:0] oscillator_control;
    logic [31:0] tuning_word;
    logic [15:0] phase_offset;
    logic [23:0] count;
    logic [31:0] phase;
    logic [7:0] rdata;
    logic start;
  } smnco_state_t;
  smnco_state_t state, next_state;
  logic [19:0] result_a;
  logic [19:0] result_b;
  logic done;
  logic [7:0] rd;

  assign done = state.monitor_control[smnco_ctl_enable] && (state.count == 24'h000001);

  smnco_chan #(.sample_w(sample_w)) u_chan_a (
    .clk(clk),
    .rst(rst),
    .sample(sample_a),
    .mode(state.monitor_control[smnco_ctl_mode_lo +: 2]),
    .ms_sel(state.monitor_control[smnco_ctl_ms_sel]),
    .threshold(threshold),
    .start(state.start),
    .done(done),
    .result(result_a)
  );

  smnco_chan #(.sample_w(sample_w)) u_chan_b (
    .clk(clk),
    .rst(rst),
    .sample(sample_b),
    .mode(state.monitor_control[smnco_ctl_mode_lo +: 2]),
    .ms_sel(state.monitor_control[smnco_ctl_ms_sel]),
    .threshold(threshold),
    .start(state.start),
    .done(done),
    .result(result_b)
  );

  always_comb begin
    rd = 8'h00;
    case (reg_addr)
      smnco_monitor_control: rd = state.monitor_control;
      smnco_period_low: rd = state.period[7:0];
      smnco_period_mid: rd = state.period[15:8];
      smnco_period_high: rd = state.period[23:16];
      // channel a and b bytes, top nibble open
      smnco_result_a_low: rd = result_a[7:0];
      smnco_result_a_mid: rd = result_a[15:8];
      smnco_result_a_high: rd = {4'h0, result_a[19:16]};
      smnco_result_b_low: rd = result_b[7:0];
      smnco_result_b_mid: rd = result_b[15:8];
      smnco_result_b_high: rd = {4'h0, result_b[19:16]};
      smnco_oscillator_control: rd = {5'h00, state.oscillator_control[2:0]};
      smnco_tuning_byte0: rd = state.tuning_word[7:0];
      smnco_tuning_byte1: rd = state.tuning_word[15:8];
      smnco_tuning_byte2: rd = state.tuning_word[23:16];
      smnco_tuning_byte3: rd = state.tuning_word[31:24];
      smnco_phase_byte0: rd = state.phase_offset[7:0];
      smnco_phase_byte1: rd = state.phase_offset[15:8];
      default: rd = 8'h00;
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.rdata = rd;
    next_state.start = 1'b0;
    if (reg_write) begin
      case (reg_addr)
        smnco_monitor_control: next_state.monitor_control = {reg_wdata[7], 3'h0, reg_wdata[3:0]};
        smnco_period_low: next_state.period[7:0] = reg_wdata;
        smnco_period_mid: next_state.period[15:8] = reg_wdata;
        smnco_period_high: next_state.period[23:16] = reg_wdata;
        smnco_oscillator_control: next_state.oscillator_control = {5'h00, reg_wdata[2:0]};
        smnco_tuning_byte0: next_state.tuning_word[7:0] = reg_wdata;
        smnco_tuning_byte1: next_state.tuning_word[15:8] = reg_wdata;
        smnco_tuning_byte2: next_state.tuning_word[23:16] = reg_wdata;
        smnco_tuning_byte3: next_state.tuning_word[31:24] = reg_wdata;
        smnco_phase_byte0: next_state.phase_offset[7:0] = reg_wdata;
        smnco_phase_byte1: next_state.phase_offset[15:8] = reg_wdata;
        default: next_state.rdata = rd;
      endcase
    end
    // period counter, a zero period is treated as one cycle
    // a control write opens a fresh window so no sum mixes two modes
    if (!state.monitor_control[smnco_ctl_enable] || state.count <= 24'h000001 ||
        (reg_write && reg_addr == smnco_monitor_control)) begin
      next_state.count = (state.period == 24'h0) ? 24'h000001 : state.period;
      next_state.start = 1'b1;
    end else begin
      next_state.count = state.count - 24'h000001;
    end
    if (sync_pulse && master_sync_enable && oscillator_sync_gate)
      next_state.phase = {state.phase_offset, 16'h0000};
    else if (state.oscillator_control[smnco_osc_enable])
      next_state.phase = state.phase + state.tuning_word;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
      state.period <= smnco_period_reset;
      state.count <= smnco_period_reset;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign monitor_enable = state.monitor_control[smnco_ctl_enable];
  assign complex_power_mode = state.monitor_control[smnco_ctl_complex];
  assign tuning_oscillator_phase = state.phase;
  assign oscillator_enable = state.oscillator_control[smnco_osc_enable];
  assign amplitude_dither = state.oscillator_control[smnco_osc_amp_dither];
  assign phase_dither = state.oscillator_control[smnco_osc_phase_dither];

  sync_reload_a: assert property (@(posedge clk) disable iff (rst)
    sync_pulse && master_sync_enable && oscillator_sync_gate |=> tuning_oscillator_phase[31:16] == $past(state.phase_offset))
    else $error("phase not reloaded on sync");
  tuning_lane_a: assert property (@(posedge clk) disable iff (rst)
    reg_write && reg_addr == smnco_tuning_byte3 |=> state.tuning_word[31:24] == $past(reg_wdata))
    else $error("tuning byte3 lane wrong");
  period_reset_a: assert property (@(posedge clk) $fell(rst) |-> state.period == 24'h000080)
    else $error("period reset value wrong");
  result_a_top_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_result_a_high |=> reg_rdata[7:4] == 4'h0)
    else $error("result a top nibble not zero");
  result_b_read_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_result_b_high |=> reg_rdata[3:0] == $past(result_b[19:16]))
    else $error("result b high nibble wrong");
  mode_peak_a: assert property (@(posedge clk) disable iff (rst)
    done && state.monitor_control[2:1] == smnco_mode_peak |=> result_a <= 20'(2 ** sample_w - 1))
    else $error("peak result out of range");

  // steps of a monitor window and of a sync restart
  sequence window_close_s;
    done;
  endsequence

  sequence window_open_s;
    state.start;
  endsequence

  sequence sync_hit_s;
    sync_pulse && master_sync_enable && oscillator_sync_gate;
  endsequence

  sequence osc_free_s;
    !(sync_pulse && master_sync_enable && oscillator_sync_gate);
  endsequence

  window_restart_a: assert property (@(posedge clk) disable iff (rst)
    window_close_s |=> window_open_s)
    else $error("window did not restart after close");

  period_reload_a: assert property (@(posedge clk) disable iff (rst)
    window_close_s |=> state.count == (($past(state.period) == 24'h000000) ? 24'h000001 : $past(state.period)))
    else $error("window count not reloaded from period");

  count_step_a: assert property (@(posedge clk) disable iff (rst)
    monitor_enable && state.count > 24'h000001 && !(reg_write && reg_addr == smnco_monitor_control) |=>
      state.count == $past(state.count) - 24'h000001)
    else $error("window count did not step down");

  idle_restart_a: assert property (@(posedge clk) disable iff (rst)
    !monitor_enable |=> window_open_s)
    else $error("idle monitor did not restart window");

  ctl_restart_a: assert property (@(posedge clk) disable iff (rst)
    reg_write && reg_addr == smnco_monitor_control |=> window_open_s)
    else $error("control write did not restart window");

  result_hold_a: assert property (@(posedge clk) disable iff (rst)
    !done |=> $stable(result_a) && $stable(result_b))
    else $error("result changed inside a window");

  monitor_ctl_a: assert property (@(posedge clk) disable iff (rst)
    reg_write && reg_addr == smnco_monitor_control |=>
      state.monitor_control == {$past(reg_wdata[7]), 3'h0, $past(reg_wdata[3:0])})
    else $error("monitor control write wrong");

  monitor_open_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_monitor_control |=> reg_rdata[6:4] == 3'h0)
    else $error("monitor control open bits set");

  mode_peak_b_a: assert property (@(posedge clk) disable iff (rst)
    done && state.monitor_control[2:1] == smnco_mode_peak |=> result_b <= 20'(2 ** sample_w - 1))
    else $error("peak result b out of range");

  result_a_low_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_result_a_low |=> reg_rdata == $past(result_a[7:0]))
    else $error("result a low byte wrong");

  result_a_mid_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_result_a_mid |=> reg_rdata == $past(result_a[15:8]))
    else $error("result a middle byte wrong");

  result_a_nib_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_result_a_high |=> reg_rdata[3:0] == $past(result_a[19:16]))
    else $error("result a top nibble wrong");

  result_b_low_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_result_b_low |=> reg_rdata == $past(result_b[7:0]))
    else $error("result b low byte wrong");

  result_b_mid_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_result_b_mid |=> reg_rdata == $past(result_b[15:8]))
    else $error("result b middle byte wrong");

  result_b_top_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_result_b_high |=> reg_rdata[7:4] == 4'h0)
    else $error("result b top nibble not zero");

  result_ro_a: assert property (@(posedge clk) disable iff (rst)
    reg_write && reg_addr >= smnco_result_a_low && reg_addr <= smnco_result_b_high |=>
      $stable(state.monitor_control) && $stable(state.period) && $stable(state.oscillator_control) &&
      $stable(state.tuning_word) && $stable(state.phase_offset))
    else $error("write to result byte changed a register");

  osc_ctl_a: assert property (@(posedge clk) disable iff (rst)
    reg_write && reg_addr == smnco_oscillator_control |=> state.oscillator_control == {5'h00, $past(reg_wdata[2:0])})
    else $error("oscillator control write wrong");

  osc_open_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_oscillator_control |=> reg_rdata[7:3] == 5'h00)
    else $error("oscillator control open bits set");

  tuning_low_a: assert property (@(posedge clk) disable iff (rst)
    reg_write && reg_addr == smnco_tuning_byte0 |=> state.tuning_word[7:0] == $past(reg_wdata))
    else $error("tuning byte0 lane wrong");

  tuning_read_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_tuning_byte2 |=> reg_rdata == $past(state.tuning_word[23:16]))
    else $error("tuning byte2 readback wrong");

  phase_step_a: assert property (@(posedge clk) disable iff (rst)
    osc_free_s ##0 oscillator_enable |=> tuning_oscillator_phase == $past(state.phase) + $past(state.tuning_word))
    else $error("phase did not advance by tuning word");

  phase_hold_a: assert property (@(posedge clk) disable iff (rst)
    osc_free_s ##0 !oscillator_enable |=> $stable(tuning_oscillator_phase))
    else $error("phase moved while oscillator off");

  sync_fraction_a: assert property (@(posedge clk) disable iff (rst)
    sync_hit_s |=> tuning_oscillator_phase[15:0] == 16'h0000)
    else $error("phase fraction not cleared on sync");

  phase_lane_a: assert property (@(posedge clk) disable iff (rst)
    reg_write && reg_addr == smnco_phase_byte1 |=> state.phase_offset[15:8] == $past(reg_wdata))
    else $error("phase offset byte1 lane wrong");

  period_lane_a: assert property (@(posedge clk) disable iff (rst)
    reg_write && reg_addr == smnco_period_low |=> state.period[7:0] == $past(reg_wdata))
    else $error("period low lane wrong");

  period_read_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == smnco_period_low |=> reg_rdata == $past(state.period[7:0]))
    else $error("period low readback wrong");

  unmapped_read_a: assert property (@(posedge clk) disable iff (rst)
    reg_addr == 10'h11c |=> reg_rdata == 8'h00)
    else $error("unmapped address read not zero");
endmodule

/* bench/smnco_host.sv */
`timescale 1ns/1ps
module smnco_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [9:0] reg_addr,
  output logic reg_write,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 10'h000;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
  end
  // called at a falling edge; the rising edge between takes the request
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    reg_wdata = ~v;
    // let an edge pass so a following call never reassigns the strobe in this time step
    @(negedge clk);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    reg_addr = a;
    @(negedge clk);
    v = reg_rdata;
  endtask
endmodule

/* bench/smnco_regs_test.sv */
`timescale 1ns/1ps
module smnco_regs_test;
  import smnco_pkg::*;
  logic clk, rst, sync_pulse, master_sync_enable, oscillator_sync_gate, reg_write;
  logic [13:0] sample_a, sample_b, threshold;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic monitor_enable, complex_power_mode, oscillator_enable, amplitude_dither, phase_dither;
  logic [31:0] tuning_oscillator_phase, p0;
  logic [9:0] ra [7] = '{10'h112, 10'h113, 10'h114, 10'h115, 10'h11d, 10'h11e, 10'h11f};
  logic [7:0] rv [7] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int err_count, checked;
  smnco_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata));
  smnco_regs dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sample_a(sample_a), .sample_b(sample_b), .threshold(threshold),
    .sync_pulse(sync_pulse), .master_sync_enable(master_sync_enable),
    .oscillator_sync_gate(oscillator_sync_gate), .monitor_enable(monitor_enable),
    .complex_power_mode(complex_power_mode), .tuning_oscillator_phase(tuning_oscillator_phase),
    .oscillator_enable(oscillator_enable), .amplitude_dither(amplitude_dither), .phase_dither(phase_dither));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tune(input logic [31:0] w);
    for (int i = 0; i < 4; i++) host.wr(smnco_tuning_byte0 + 10'(i), w[8*i +: 8]);
  endtask
  // constant samples make every full window give the same figure
  task automatic result(input logic [3:0] ctl, input logic [13:0] sa, sb, input logic [19:0] ea, eb);
    logic [47:0] v;
    v = {4'h0, eb, 4'h0, ea};
    sample_a = sa;
    sample_b = sb;
    host.wr(smnco_monitor_control, {4'h0, ctl});
    repeat (20) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      host.rd(smnco_result_a_low + 10'(i), d);
      check(d, v[8*i +: 8]);
    end
  endtask
  initial begin
    rst = 1'b1;
    {sync_pulse, master_sync_enable, oscillator_sync_gate} = 3'h0;
    {sample_a, sample_b} = 28'h0;
    threshold = 14'h0032;
    err_count = 0;
    checked = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      host.rd(ra[i], d);
      check(d, rv[i]);
    end
    check({monitor_enable, complex_power_mode, oscillator_enable, amplitude_dither, phase_dither}, 5'h00);
    check(tuning_oscillator_phase, 32'h00000000);
    host.wr(10'h11c, 8'hff);
    host.rd(10'h11c, d);
    check(d, 8'h00);
    host.wr(smnco_result_b_mid, 8'hff);
    host.rd(smnco_result_b_mid, d);
    check(d, 8'h00);
    host.wr(smnco_period_low, 8'h04);
    host.rd(smnco_period_low, d);
    check(d, 8'h04);
    result(4'h3, 14'd100, 14'd200, 20'd100, 20'd200);
    result(4'h5, 14'd100, 14'd20, 20'd4, 20'd0);
    result(4'h7, 14'd20, 14'd100, 20'd0, 20'd4);
    result(4'h1, 14'd16383, 14'd0, 20'd32766, 20'd0);
    result(4'h9, 14'd16383, 14'd0, 20'd1023, 20'd0);
    host.wr(smnco_monitor_control, 8'h81);
    check({monitor_enable, complex_power_mode}, 2'h3);
    tune(32'h04030201);
    for (int i = 0; i < 4; i++) begin
      host.rd(smnco_tuning_byte0 + 10'(i), d);
      check(d, 8'(i + 1));
    end
    host.wr(smnco_oscillator_control, 8'h07);
    check({oscillator_enable, amplitude_dither, phase_dither}, 3'h7);
    p0 = tuning_oscillator_phase;
    @(negedge clk);
    check(tuning_oscillator_phase - p0, 32'h04030201);
    host.wr(smnco_oscillator_control, 8'h01);
    check({oscillator_enable, amplitude_dither, phase_dither}, 3'h4);
    tune(32'h0);
    host.wr(smnco_phase_byte0, 8'h34);
    host.wr(smnco_phase_byte1, 8'h12);
    master_sync_enable = 1'b1;
    for (int g = 0; g < 2; g++) begin
      oscillator_sync_gate = g[0];
      p0 = tuning_oscillator_phase;
      sync_pulse = 1'b1;
      @(negedge clk);
      sync_pulse = 1'b0;
      repeat (2) @(negedge clk);
      check(tuning_oscillator_phase[31:16], g ? 16'h1234 : p0[31:16]);
    end
    test_done();
  end
  initial begin
    #20000;
    err_count++;
    test_done();
  end
endmodule
